// file: sim/sac_host_model.sv
// Far-side model: analog comparator and external link clock of the host
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sac_host_model (
  input wire logic [15:0] sample_i,
  input wire logic [15:0] dac_trial_i,
  input wire logic frame_i,
  output logic cmp_o,
  output logic sclk_o
);
  // Trial bit is kept while the held sample is at or above the trial code
  assign cmp_o = (sample_i >= dac_trial_i);
  // Link clock of 48 ns, parked low outside frames
  initial sclk_o = 1'b0;
  always #24 sclk_o = frame_i ? ~sclk_o : 1'b0;
endmodule

// file: sim/tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (a), (b)); end end

////////////////////////////////////////////////////////////////////////////////
module tb;
  import sac_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_n = 1'b1, cs_n = 1'b1, rd_n = 1'b1, pd = 1'b0;
  logic ser = 1'b0, ext = 1'b0, inv = 1'b0, rdc = 1'b0, frame = 1'b0;
  logic [15:0] sample = 16'h0000;
  logic [15:0] rx, dac, data_o, data_oe_o;
  logic cmp, sclk, busy_o, hold_o, power_save_o, sout, sout_oe, flag;
  logic mclk, mclk_oe;
  int errors = 0, total_checks = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  sac_ctrl sac_ctrl_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .convert_start_n_i(start_n), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .power_down_request_i(pd), .serial_parallel_select_i(ser),
    .clock_source_select_i(ext), .shift_clock_invert_i(inv),
    .read_during_convert_select_i(rdc), .cmp_i(cmp), .sclk_i(sclk), .busy_o(busy_o),
    .hold_o(hold_o), .dac_trial_o(dac), .power_save_o(power_save_o), .data_o(data_o),
    .data_oe_o(data_oe_o), .serial_result_out_o(sout), .serial_result_oe_o(sout_oe),
    .sclk_o(mclk), .sclk_oe_o(mclk_oe), .incomplete_read_flag_o(flag)
  );

  sac_host_model sac_host_model_inst (
    .sample_i(sample), .dac_trial_i(dac), .frame_i(frame), .cmp_o(cmp), .sclk_o(sclk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy_o !== lvl && n < 400)
    begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask

  // Host triggers by a falling edge after acquisition and waits for busy to fall
  task automatic convert(input logic [15:0] s);
    int n;
    sample = s;
    repeat (60) @(negedge clk_sys_i);
    start_n = 1'b0;
    wait_busy(1'b1, n);
    `CHK(hold_o, 1'b1)
    @(negedge clk_sys_i);
    start_n = 1'b1;
    wait_busy(1'b0, n);
    `CHK(n >= 128, 1'b1)
    repeat (4) @(negedge clk_sys_i);
  endtask

  task automatic t_edge();
    convert(16'hA5C3);
    `CHK(data_o, 16'hA5C3)
    $display("edge start done");
  endtask

  task automatic t_level();
    int n;
    convert(16'h1234);
    start_n = 1'b0;
    wait_busy(1'b1, n);
    sample = 16'hFFFF;
    wait_busy(1'b0, n);
    sample = 16'h0001;
    wait_busy(1'b1, n);
    `CHK(n <= 60, 1'b1)
    start_n = 1'b1;
    wait_busy(1'b0, n);
    repeat (4) @(negedge clk_sys_i);
    `CHK(data_o, 16'h0001)
    $display("level start done");
  endtask

  task automatic t_parallel();
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    `CHK(data_oe_o, 16'hFFFF)
    `CHK(data_o, 16'h0001)
    rd_n = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    `CHK(data_oe_o, 16'hF000)
    cs_n = 1'b1;
    $display("parallel read done");
  endtask

  task automatic t_power_down();
    int n;
    sample = 16'h7FFF;
    repeat (60) @(negedge clk_sys_i);
    start_n = 1'b0;
    wait_busy(1'b1, n);
    pd = 1'b1;
    start_n = 1'b1;
    wait_busy(1'b0, n);
    `CHK(busy_o, 1'b0)
    repeat (4) @(negedge clk_sys_i);
    `CHK(data_o, 16'h7FFF)
    start_n = 1'b0;
    repeat (300) @(negedge clk_sys_i);
    `CHK(busy_o, 1'b0)
    `CHK(power_save_o, 1'b1)
    pd = 1'b0;
    start_n = 1'b1;
    $display("power down done");
  endtask

  task automatic t_reset_abort();
    int n;
    repeat (60) @(negedge clk_sys_i);
    start_n = 1'b0;
    wait_busy(1'b1, n);
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b1;
    start_n = 1'b1;
    @(negedge clk_sys_i);
    `CHK(busy_o, 1'b0)
    `CHK(hold_o, 1'b0)
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    $display("reset abort done");
  endtask

  // Slave read; data sampled on the edge opposite the update edge
  task automatic t_slave(input logic iv);
    ser = 1'b1;
    ext = 1'b1;
    inv = iv;
    convert(iv ? 16'h3C96 : 16'hC369);
    frame = 1'b1;
    repeat (4) @(posedge sclk);
    frame = 1'b0;
    @(negedge sclk);
    @(negedge clk_sys_i);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    `CHK(sout_oe, 1'b1)
    rx = {15'h0000, sout};
    frame = 1'b1;
    if (iv) @(posedge sclk);
    repeat (15)
    begin
      if (iv) @(posedge sclk); else @(negedge sclk);
      rx = {rx[14:0], sout};
    end
    if (iv) @(negedge sclk); else @(posedge sclk);
    frame = 1'b0;
    `CHK(rx, iv ? 16'h3C96 : 16'hC369)
    @(negedge clk_sys_i);
    cs_n = 1'b1;
    rd_n = 1'b1;
    $display("slave read done");
  endtask

  task automatic t_overrun();
    logic seen;
    seen = 1'b0;
    ser = 1'b1;
    ext = 1'b1;
    inv = 1'b0;
    convert(16'h5A5A);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    frame = 1'b1;
    repeat (3) @(posedge sclk);
    frame = 1'b0;
    @(negedge clk_sys_i);
    start_n = 1'b0;
    repeat (400)
    begin
      @(negedge clk_sys_i);
      if (flag === 1'b1) seen = 1'b1;
    end
    `CHK(seen, 1'b1)
    cs_n = 1'b1;
    rd_n = 1'b1;
    start_n = 1'b1;
    $display("incomplete read done");
  endtask

  // Internal shift clock read; host samples the serial output on each rise
  task automatic t_master(input logic rd_mode, input logic [15:0] s, input logic [15:0] exp);
    int n;
    logic prev;
    logic [15:0] v;
    ser = 1'b1;
    ext = 1'b0;
    rdc = rd_mode;
    cs_n = 1'b1;
    rd_n = 1'b1;
    sample = s;
    repeat (200) @(negedge clk_sys_i);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    `CHK(mclk_oe, 1'b1)
    start_n = 1'b0;
    wait_busy(1'b1, n);
    @(negedge clk_sys_i);
    start_n = 1'b1;
    if (!rd_mode)
      wait_busy(1'b0, n);
    v = 16'h0000;
    prev = mclk;
    n = 0;
    repeat (400)
    begin
      @(negedge clk_sys_i);
      if (mclk === 1'b1 && prev === 1'b0)
      begin
        v = {v[14:0], sout};
        n++;
      end
      prev = mclk;
    end
    `CHK(n, 16)
    `CHK(v, exp)
    `CHK(data_o, s)
    cs_n = 1'b1;
    rd_n = 1'b1;
    $display("master read done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    `CHK(data_oe_o, 16'hF000)
    `CHK(busy_o, 1'b0)
    t_edge();
    t_level();
    t_parallel();
    t_power_down();
    t_reset_abort();
    t_slave(1'b0);
    t_slave(1'b1);
    t_overrun();
    t_master(1'b0, 16'h6B1D, 16'h6B1D);
    t_master(1'b1, 16'h4E27, 16'h6B1D);
    print_verdict();
  end
endmodule

// file: src/sac_ctrl.sv
// Conversion control, result FIFO and parallel/serial read port
//
// Overview of operation
// - slave read overrun pulses error, new result still queued
// - parallel bits 12 to 15 always driven
// - busy from start until result latched
// - output bus bits 0 to 11 enabled only with select and read
// - select gates the external shift clock
// - reset aborts conversion, returns to idle
// - power-down finishes conversion, then blocks starts
// - start high at acquisition end waits edge
// - start low at acquisition end converts immediately
// - serial result shifts out MSB first
// - invert input picks external shift clock update edge
// - read mode picks during or after conversion
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sac_fifo_t;
  sac_fifo_t f_reg, f_next;
  logic push, pop;

  assign in_ready_o = f_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = f_reg.cnt != '0;
  assign out_data_o = f_reg.mem[f_reg.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb
  begin
    f_next = f_reg;
    if (push)
    begin
      f_next.mem[f_reg.wp] = in_data_i;
      f_next.wp = f_reg.wp + 1'b1;
    end
    if (pop)
      f_next.rp = f_reg.rp + 1'b1;
    if (push && !pop)
      f_next.cnt = f_reg.cnt + 1'b1;
    else if (pop && !push)
      f_next.cnt = f_reg.cnt - 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      f_reg <= '0;
    else
      f_reg <= f_next;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sac_ctrl
  import sac_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic convert_start_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic power_down_request_i,
  input wire logic serial_parallel_select_i,
  input wire logic clock_source_select_i,
  input wire logic shift_clock_invert_i,
  input wire logic read_during_convert_select_i,
  input wire logic cmp_i,
  input wire logic sclk_i,
  output logic busy_o,
  output logic hold_o,
  output logic [15:0] dac_trial_o,
  output logic power_save_o,
  output logic [15:0] data_o,
  output logic [15:0] data_oe_o,
  output logic serial_result_out_o,
  output logic serial_result_oe_o,
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic incomplete_read_flag_o
);
  typedef struct packed {
    sac_state_t st;
    logic [7:0] tmr;
    logic [3:0] bit_idx;
    logic [15:0] sar;
    logic [15:0] word;
    logic word_vld;
    logic [2:0] cnv_s;
    logic [1:0] cs_s;
    logic [1:0] rd_s;
    logic [1:0] cmp_s;
    logic [2:0] done_s;
    logic [3:0] cfg_s1;
    logic [3:0] cfg_s2;
    logic rd_active;
    logic err;
    logic ms_act;
    logic [7:0] ms_div;
    logic [4:0] ms_cnt;
    logic ms_clk;
    logic [15:0] ms_sh;
  } sac_sys_t;
  typedef struct packed {
    logic [4:0] cnt;
    logic [15:0] sh;
    logic done;
  } sac_link_t;

  sac_sys_t q_reg, q_next;
  sac_link_t l_reg, l_next;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [15:0] fifo_data;
  logic sel, ser, ext, rdc, pd, slave, master, cnv_fall, cnv_low, rd_done;
  logic conv_go, ms_go, link_clk, link_rst;

  assign sel = ~q_reg.cs_s[1] & ~q_reg.rd_s[1];
  assign ser = q_reg.cfg_s2[CFG_SER];
  assign ext = q_reg.cfg_s2[CFG_EXT];
  assign rdc = q_reg.cfg_s2[CFG_RDC];
  assign pd = q_reg.cfg_s2[CFG_PD];
  assign slave = ser & ext;
  assign master = ser & ~ext;
  assign cnv_fall = q_reg.cnv_s[2] & ~q_reg.cnv_s[1];
  assign cnv_low = ~q_reg.cnv_s[1];
  assign rd_done = q_reg.done_s[1] & ~q_reg.done_s[2];
  // Word is only replaced while no read is using it; the internal shifter takes its own copy
  assign fifo_pop = fifo_out_valid & ~q_reg.ms_act & ~q_reg.rd_active & (~sel | master);

  sac_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(q_reg.st == ST_LATCH),
    .in_ready_o(fifo_in_ready),
    .in_data_i(q_reg.sar),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // System clock domain: conversion sequencing and internal shift clock
  always_comb
  begin
    q_next = q_reg;
    q_next.err = 1'b0;
    conv_go = 1'b0;
    ms_go = 1'b0;
    q_next.cnv_s = {q_reg.cnv_s[1:0], convert_start_n_i};
    q_next.cs_s = {q_reg.cs_s[0], cs_n_i};
    q_next.rd_s = {q_reg.rd_s[0], rd_n_i};
    q_next.cmp_s = {q_reg.cmp_s[0], cmp_i};
    q_next.done_s = {q_reg.done_s[1:0], l_reg.done};
    q_next.cfg_s1 = {power_down_request_i, read_during_convert_select_i,
      clock_source_select_i, serial_parallel_select_i};
    q_next.cfg_s2 = q_reg.cfg_s1;
    unique case (q_reg.st)
      ST_ACQ:
      begin
        if (q_reg.tmr != 8'h00)
          q_next.tmr = q_reg.tmr - 8'h01;
        else if (pd)
          q_next.st = ST_PDN;
        else if (cnv_low)
          conv_go = 1'b1;
        else
          q_next.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (pd)
          q_next.st = ST_PDN;
        else if (cnv_fall)
          conv_go = 1'b1;
      end
      ST_CONV:
      begin
        if (q_reg.tmr != 8'h00)
          q_next.tmr = q_reg.tmr - 8'h01;
        else
        begin
          q_next.sar[q_reg.bit_idx] = q_reg.cmp_s[1];
          if (q_reg.bit_idx == 4'h0)
            q_next.st = ST_LATCH;
          else
          begin
            q_next.bit_idx = q_reg.bit_idx - 4'h1;
            q_next.sar[q_reg.bit_idx - 4'h1] = 1'b1;
            q_next.tmr = BIT_CNT;
          end
        end
      end
      ST_LATCH:
      begin
        // Busy holds until the result is accepted by the output path
        if (fifo_in_ready)
        begin
          q_next.st = ST_ACQ;
          q_next.tmr = ACQ_CNT;
          if (slave && q_reg.rd_active)
          begin
            q_next.err = 1'b1;
            q_next.word_vld = 1'b0;
          end
        end
      end
      ST_PDN:
      begin
        if (!pd)
        begin
          q_next.st = ST_ACQ;
          q_next.tmr = ACQ_CNT;
        end
      end
    endcase
    if (conv_go)
    begin
      q_next.st = ST_CONV;
      q_next.bit_idx = MSB_IDX;
      q_next.sar = SAR_FIRST;
      q_next.tmr = BIT_CNT;
      ms_go = master & rdc & sel & q_reg.word_vld;
    end
    // Slave read in progress: set while selected, until all bits shifted
    if (rd_done || !sel || q_next.err)
      q_next.rd_active = 1'b0;
    else if (slave && !q_reg.done_s[1])
      q_next.rd_active = 1'b1;
    if (fifo_pop)
    begin
      q_next.word = fifo_data;
      q_next.word_vld = 1'b1;
      ms_go = ms_go | (master & ~rdc & sel);
    end
    if (ms_go && !q_reg.ms_act)
    begin
      q_next.ms_act = 1'b1;
      q_next.ms_sh = fifo_pop ? fifo_data : q_reg.word;
      q_next.ms_cnt = BITS_PER_WORD;
      q_next.ms_div = HALF_CNT;
      q_next.ms_clk = 1'b0;
    end
    else if (q_reg.ms_act)
    begin
      if (q_reg.ms_div != 8'h00)
        q_next.ms_div = q_reg.ms_div - 8'h01;
      else
      begin
        q_next.ms_div = HALF_CNT;
        q_next.ms_clk = ~q_reg.ms_clk;
        if (q_reg.ms_clk)
        begin
          q_next.ms_sh = {q_reg.ms_sh[14:0], 1'b0};
          q_next.ms_cnt = q_reg.ms_cnt - 5'h01;
          q_next.ms_act = q_reg.ms_cnt != 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q_reg <= '0;
      q_reg.tmr <= ACQ_CNT;
      q_reg.cnv_s <= 3'h7;
      q_reg.cs_s <= 2'h3;
      q_reg.rd_s <= 2'h3;
    end
    else
      q_reg <= q_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: external shift clock, gated by select, edge picked by invert
  assign link_clk = sclk_i ^ shift_clock_invert_i;
  assign link_rst = rst_i | cs_n_i;

  always_comb
  begin
    l_next = l_reg;
    // Word is held still while a slave read is active
    if (l_reg.cnt == 5'h00)
    begin
      l_next.sh = {q_reg.word[14:0], 1'b0};
      l_next.cnt = 5'h01;
    end
    else if (l_reg.cnt != BITS_PER_WORD)
    begin
      l_next.sh = {l_reg.sh[14:0], 1'b0};
      l_next.cnt = l_reg.cnt + 5'h01;
    end
    l_next.done = l_next.cnt == BITS_PER_WORD;
  end

  always_ff @(posedge link_clk or posedge link_rst)
  begin
    if (link_rst)
      l_reg <= '0;
    else
      l_reg <= l_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pins
  assign busy_o = (q_reg.st == ST_CONV) || (q_reg.st == ST_LATCH);
  assign hold_o = q_reg.st == ST_CONV;
  assign dac_trial_o = q_reg.sar;
  assign power_save_o = q_reg.st == ST_PDN;
  assign data_o = q_reg.word;
  assign data_oe_o = {4'hF, {12{sel & ~ser}}};
  assign serial_result_oe_o = sel & ser;
  assign serial_result_out_o = ext ? ((l_reg.cnt == 5'h00) ? q_reg.word[15] : l_reg.sh[15])
    : q_reg.ms_sh[15];
  assign sclk_o = q_reg.ms_clk;
  assign sclk_oe_o = master;
  assign incomplete_read_flag_o = q_reg.err;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_edge_start: assert property ((q_reg.st == ST_WAIT && cnv_fall && !pd) |=> busy_o)
    else $error("falling start edge did not begin conversion");
  a_low_start: assert property ((q_reg.st == ST_ACQ && q_reg.tmr == 8'h00 && !pd && cnv_low)
    |=> (busy_o && hold_o))
    else $error("low start at acquisition end did not convert");
  a_wait_edge: assert property ((q_reg.st == ST_WAIT && !cnv_fall) |=> !busy_o)
    else $error("conversion began without start edge");
  a_busy_fall: assert property ($fell(busy_o) |-> $past(q_reg.st) == ST_LATCH
    && $past(fifo_in_ready))
    else $error("busy fell before result was latched");
  a_top_bits_out: assert property (data_oe_o[15:12] == 4'hF)
    else $error("parallel bits 12 to 15 not driven");
  a_bus_gate: assert property ((serial_result_oe_o || data_oe_o[0])
    |-> $past(!cs_n_i && !rd_n_i, 2))
    else $error("output bus enabled without select and read");
  a_err_pulse: assert property (incomplete_read_flag_o |-> (slave && !q_reg.rd_active)
    ##1 !incomplete_read_flag_o)
    else $error("read error flag not a single slave mode pulse");
  a_pd_finish: assert property ((q_reg.st == ST_CONV && pd)
    |=> (q_reg.st == ST_CONV || q_reg.st == ST_LATCH))
    else $error("power-down cut a conversion short");
  a_pd_block: assert property ((q_reg.st == ST_PDN && pd) |=> !busy_o)
    else $error("conversion started during power-down");

  c_conv_done: cover property ($fell(busy_o));
  c_read_error: cover property (incomplete_read_flag_o);
  c_power_down: cover property (q_reg.st == ST_PDN ##1 q_reg.st == ST_ACQ);
  c_master_shift: cover property ($fell(q_reg.ms_act));
endmodule

// file: src/sac_pkg.sv
// Constants and types shared by the converter control block
package sac_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RES_W = 16;
  localparam int FIFO_DEPTH = 32;
  // Acquisition time, SAR bit-trial time, internal shift clock half period
  localparam int T_ACQ_NS = 250;
  localparam int T_BIT_NS = 40;
  localparam int T_SCLK_HALF_NS = 20;
  localparam int ACQ_CYC = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CYC = (T_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CYC = (T_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ACQ_CNT = 8'(ACQ_CYC - 1);
  localparam logic [7:0] BIT_CNT = 8'(BIT_CYC - 1);
  localparam logic [7:0] HALF_CNT = 8'(HALF_CYC - 1);
  localparam logic [4:0] BITS_PER_WORD = 5'h10;
  localparam logic [3:0] MSB_IDX = 4'hF;
  localparam logic [15:0] SAR_FIRST = 16'h8000;
  // Config sync vector positions
  localparam int CFG_SER = 0;
  localparam int CFG_EXT = 1;
  localparam int CFG_RDC = 2;
  localparam int CFG_PD = 3;
  typedef enum logic [2:0] {
    ST_ACQ = 3'h0,
    ST_WAIT = 3'h1,
    ST_CONV = 3'h2,
    ST_LATCH = 3'h3,
    ST_PDN = 3'h4
  } sac_state_t;
endpackage
